// >>> verif/ssr_core_test.sv
`timescale 1ns/10ps
module ssr_core_test;
    import ssr_pkg::*;
    logic              clk = 1'b0;
    logic              reset = 1'b1;
    logic [ADDR_W-1:0] addr = 14'h0000;
    logic              we_n = 1'b1, sel = 1'b0, sel_n = 1'b1, wel_n = 1'b1, weh_n = 1'b1;
    logic              oe_n = 1'b1, gate = 1'b1, drv = 1'b0;
    logic [WORD_W-1:0] word = 18'h00000;
    logic [WORD_W-1:0] bus, seen;
    logic [PINS_W-1:0] pins_out;
    logic              pins_oe, lo_out, lo_oe, hi_out, hi_oe;
    logic [2:0]        seen_oe;
    int                failures = 0, checked = 0, cycles = 0;

    always #2.5 clk = ~clk;

    ssr_core dut (.clk(clk), .reset(reset), .word_index_inputs(addr),
        .registered_write_strobe_n(we_n), .registered_chip_select(sel),
        .registered_chip_select_n(sel_n), .low_byte_write_strobe_n(wel_n),
        .high_byte_write_strobe_n(weh_n), .output_enable_n(oe_n), .input_latch_gate(gate),
        .data_lane_pins_in({bus[16:9], bus[7:0]}), .data_lane_pins_out(pins_out),
        .data_lane_pins_oe(pins_oe), .low_lane_parity_in(bus[8]), .low_lane_parity_out(lo_out),
        .low_lane_parity_oe(lo_oe), .high_lane_parity_in(bus[17]),
        .high_lane_parity_out(hi_out), .high_lane_parity_oe(hi_oe));

    ssr_ctrl_model ctrl (.clk(clk), .reset(reset), .ctrl_drive(drv), .ctrl_word(word),
        .dut_pins_out(pins_out),
        .dut_pins_oe(pins_oe), .dut_lo_par_out(lo_out), .dut_lo_par_oe(lo_oe),
        .dut_hi_par_out(hi_out), .dut_hi_par_oe(hi_oe), .bus_word(bus));

    // ------------------------------------------------------------------
    // Cycle driver and compares
    // ------------------------------------------------------------------
    // Controls sampled at the edge after issue; strobes, gate and data judged one edge later.
    // The gate is high with pre on the pins at the sampling edge, so a falling gate holds pre.
    task automatic op(input logic w, s, s_n, input logic [13:0] a, input logic l, h, g, oen,
                      input logic [17:0] pre, dat);
        @(posedge clk);
        we_n <= w;
        sel <= s;
        sel_n <= s_n;
        addr <= a;
        drv <= !w;
        word <= pre;
        gate <= 1'b1;
        @(posedge clk);
        sel <= 1'b0;
        sel_n <= 1'b1;
        we_n <= 1'b1;
        wel_n <= l;
        weh_n <= h;
        gate <= g;
        word <= dat;
        oe_n <= oen;
        #1;
        seen_oe = {pins_oe, lo_oe, hi_oe};
        seen = bus;
        @(posedge clk);
        wel_n <= 1'b1;
        weh_n <= 1'b1;
        drv <= 1'b0;
        oe_n <= 1'b1;
        gate <= 1'b1;
    endtask : op

    task automatic chk_word(input logic [17:0] got, exp, input string msg);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask : chk_word

    task automatic chk_oe(input logic [2:0] exp, input string msg);
        checked++;
        if (seen_oe !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s drivers %b want %b", $time, msg, seen_oe, exp);
        end
    endtask : chk_oe

    task automatic rd(input logic [13:0] a, input logic [17:0] exp, input string msg);
        op(1'b1, 1'b1, 1'b0, a, 1'b1, 1'b1, 1'b1, 1'b0, 18'h00000, 18'h00000);
        chk_oe(3'b111, msg);
        chk_word(seen, exp, msg);
    endtask : rd

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_word;
        op(1'b0, 1'b1, 1'b0, 14'h3fff, 1'b0, 1'b0, 1'b1, 1'b1, 18'h00000, 18'h2a5c3);
        op(1'b0, 1'b1, 1'b0, 14'h0000, 1'b0, 1'b0, 1'b1, 1'b1, 18'h00000, 18'h15a3c);
        rd(14'h3fff, 18'h2a5c3, "top word");
        rd(14'h0000, 18'h15a3c, "bottom word");
        $display("test word done");
    endtask : t_word

    task automatic t_bytes;
        op(1'b0, 1'b1, 1'b0, 14'h0155, 1'b0, 1'b0, 1'b1, 1'b1, 18'h00000, 18'h3ffff);
        op(1'b0, 1'b1, 1'b0, 14'h0155, 1'b0, 1'b1, 1'b1, 1'b1, 18'h00000, 18'h00000);
        rd(14'h0155, 18'h3fe00, "low lane only");
        op(1'b0, 1'b1, 1'b0, 14'h0155, 1'b1, 1'b0, 1'b1, 1'b1, 18'h00000, 18'h00000);
        rd(14'h0155, 18'h00000, "high lane only");
        $display("test bytes done");
    endtask : t_bytes

    task automatic t_abort;
        op(1'b0, 1'b1, 1'b0, 14'h0000, 1'b1, 1'b1, 1'b0, 1'b0, 18'h3ffff, 18'h3ffff);
        chk_oe(3'b000, "aborted write drives");
        rd(14'h0000, 18'h15a3c, "abort kept word");
        op(1'b0, 1'b1, 1'b0, 14'h0000, 1'b0, 1'b0, 1'b1, 1'b0, 18'h00000, 18'h0f0f0);
        chk_oe(3'b000, "write drives");
        rd(14'h0000, 18'h0f0f0, "after abort");
        $display("test abort done");
    endtask : t_abort

    task automatic t_latch;
        op(1'b0, 1'b1, 1'b0, 14'h2001, 1'b0, 1'b0, 1'b0, 1'b1, 18'h1b2c4, 18'h24d3b);
        rd(14'h2001, 18'h1b2c4, "latched write");
        $display("test latch done");
    endtask : t_latch

    task automatic t_desel;
        op(1'b0, 1'b0, 1'b0, 14'h2001, 1'b0, 1'b0, 1'b1, 1'b0, 18'h00000, 18'h00000);
        chk_oe(3'b000, "select low");
        op(1'b0, 1'b1, 1'b1, 14'h2001, 1'b0, 1'b0, 1'b1, 1'b0, 18'h00000, 18'h00000);
        chk_oe(3'b000, "select_n high");
        op(1'b1, 1'b0, 1'b1, 14'h2001, 1'b1, 1'b1, 1'b1, 1'b0, 18'h00000, 18'h00000);
        chk_oe(3'b000, "deselected read");
        rd(14'h2001, 18'h1b2c4, "after deselect");
        $display("test deselect done");
    endtask : t_desel

    task automatic t_read;
        op(1'b1, 1'b1, 1'b0, 14'h2001, 1'b1, 1'b1, 1'b1, 1'b1, 18'h00000, 18'h00000);
        chk_oe(3'b000, "output enable high");
        op(1'b1, 1'b1, 1'b0, 14'h2001, 1'b0, 1'b0, 1'b1, 1'b0, 18'h00000, 18'h00000);
        chk_word(seen, 18'h1b2c4, "read with strobes");
        rd(14'h2001, 18'h1b2c4, "strobes ignored");
        $display("test read done");
    endtask : t_read

    // Write then read of one word on consecutive cycles: read must see the new word
    task automatic t_bypass;
        @(posedge clk);
        we_n <= 1'b0;
        sel <= 1'b1;
        sel_n <= 1'b0;
        addr <= 14'h1234;
        drv <= 1'b1;
        word <= 18'h3c3c3;
        gate <= 1'b1;
        @(posedge clk);
        we_n <= 1'b1;
        wel_n <= 1'b0;
        weh_n <= 1'b0;
        @(posedge clk);
        sel <= 1'b0;
        sel_n <= 1'b1;
        wel_n <= 1'b1;
        weh_n <= 1'b1;
        drv <= 1'b0;
        oe_n <= 1'b0;
        #1;
        seen_oe = {pins_oe, lo_oe, hi_oe};
        seen = bus;
        chk_oe(3'b111, "read after write");
        chk_word(seen, 18'h3c3c3, "read after write");
        @(posedge clk);
        oe_n <= 1'b1;
        $display("test bypass done");
    endtask : t_bypass

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    // Whole run is about 100 cycles; the ceiling leaves wide margin
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            complete_run();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        t_word();
        t_bytes();
        t_abort();
        t_latch();
        t_desel();
        t_read();
        t_bypass();
        complete_run();
    end
endmodule : ssr_core_test

// >>> verif/ssr_ctrl_model.sv
`timescale 1ns/10ps
// Controller side of the shared data pins: resolves who drives each line.
// A line nobody drives shows the inverse of its last level, never a stale copy.
module ssr_ctrl_model
    import ssr_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              ctrl_drive,
    input  wire logic [WORD_W-1:0] ctrl_word,
    input  wire logic [PINS_W-1:0] dut_pins_out,
    input  wire logic              dut_pins_oe,
    input  wire logic              dut_lo_par_out,
    input  wire logic              dut_lo_par_oe,
    input  wire logic              dut_hi_par_out,
    input  wire logic              dut_hi_par_oe,
    output logic      [WORD_W-1:0] bus_word
);
    logic [WORD_W-1:0] last_reg;
    logic [WORD_W-1:0] dut_en;
    logic [WORD_W-1:0] dut_word;

    // Word layout {hi_par, pins[15:8], lo_par, pins[7:0]}
    assign dut_en   = {dut_hi_par_oe, {8{dut_pins_oe}}, dut_lo_par_oe, {8{dut_pins_oe}}};
    assign dut_word = {dut_hi_par_out, dut_pins_out[15:8], dut_lo_par_out, dut_pins_out[7:0]};
    assign bus_word = (dut_word & dut_en) | (~dut_en & (ctrl_drive ? ctrl_word : ~last_reg));

    // Cleared in reset so an idle line never floats unknown into the input latch
    always_ff @(posedge clk) begin
        if (reset) begin
            last_reg <= '0;
        end else begin
            last_reg <= bus_word;
        end
    end
endmodule : ssr_ctrl_model

// >>> verilog/ssr_core.sv
`timescale 1ns/10ps
module ssr_core
    import ssr_pkg::*;
#(
    parameter int DEPTH = 16384
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic [ADDR_W-1:0] word_index_inputs,
    input  wire logic              registered_write_strobe_n,
    input  wire logic              registered_chip_select,
    input  wire logic              registered_chip_select_n,
    input  wire logic              low_byte_write_strobe_n,
    input  wire logic              high_byte_write_strobe_n,
    input  wire logic              output_enable_n,
    input  wire logic              input_latch_gate,
    input  wire logic [PINS_W-1:0] data_lane_pins_in,
    output logic      [PINS_W-1:0] data_lane_pins_out,
    output logic                   data_lane_pins_oe,
    input  wire logic              low_lane_parity_in,
    output logic                   low_lane_parity_out,
    output logic                   low_lane_parity_oe,
    input  wire logic              high_lane_parity_in,
    output logic                   high_lane_parity_out,
    output logic                   high_lane_parity_oe
);
    // ------------------------------------------------------------------
    // Registered inputs
    // ------------------------------------------------------------------
    ssr_cycle_t        cycle_reg, cycle_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;

    always_comb begin
        addr_next = word_index_inputs;
        if (registered_chip_select && !registered_chip_select_n) begin
            cycle_next = registered_write_strobe_n ? SSR_CYC_READ : SSR_CYC_WRITE;
        end else begin
            cycle_next = SSR_CYC_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cycle_reg <= SSR_CYC_IDLE;
            addr_reg  <= ADDR_RST;
        end else begin
            cycle_reg <= cycle_next;
            addr_reg  <= addr_next;
        end
    end

    // ------------------------------------------------------------------
    // Input data latch
    // ------------------------------------------------------------------
    // Modelled on the clock: the held word is the last one seen with the
    // gate high; with the gate high at the writing edge the pins pass straight to the write.
    logic [WORD_W-1:0] pin_word;
    logic [WORD_W-1:0] held_reg, held_next;
    logic [WORD_W-1:0] wr_word;

    always_comb begin
        pin_word = {high_lane_parity_in, data_lane_pins_in[PINS_W-1:PIN_HI_LSB],
                    low_lane_parity_in, data_lane_pins_in[PIN_HI_LSB-1:0]};
        held_next = input_latch_gate ? pin_word : held_reg;
        wr_word   = input_latch_gate ? pin_word : held_reg;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            held_reg <= WORD_RST;
        end else begin
            held_reg <= held_next;
        end
    end

    // ------------------------------------------------------------------
    // Array access
    // ------------------------------------------------------------------
    logic [LANES-1:0]  mem_we;
    logic [WORD_W-1:0] rd_word;
    logic              drive_en;

    always_comb begin
        mem_we = '0;
        if (cycle_reg == SSR_CYC_WRITE) begin
            mem_we[LANE_LO] = !low_byte_write_strobe_n;
            mem_we[LANE_HI] = !high_byte_write_strobe_n;
        end
    end

    ssr_mem_array #(
        .AW    (ADDR_W),
        .LW    (LANE_W),
        .NL    (LANES),
        .DEPTH (DEPTH)
    ) u_array (
        .clk     (clk),
        .reset   (reset),
        .wr_en   (mem_we),
        .wr_addr (addr_reg),
        .wr_data (wr_word),
        .rd_addr (word_index_inputs),
        .rd_data (rd_word)
    );

    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    // Output enable acts without the clock, as on the real pin.
    always_comb begin
        drive_en = (cycle_reg == SSR_CYC_READ) && !output_enable_n;
        data_lane_pins_oe    = drive_en;
        low_lane_parity_oe   = drive_en;
        high_lane_parity_oe  = drive_en;
        data_lane_pins_out   = {rd_word[HI_BYTE_LSB +: BYTE_W],
                                rd_word[LO_BYTE_LSB +: BYTE_W]};
        low_lane_parity_out  = rd_word[LO_PAR_BIT];
        high_lane_parity_out = rd_word[HI_PAR_BIT];
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_addr_capture: assert property (@(posedge clk) disable iff (reset)
        !$past(reset) |-> addr_reg == $past(word_index_inputs))
        else $error("word index not captured");

    chk_strobe_decode: assert property (@(posedge clk) disable iff (reset)
        cycle_reg == SSR_CYC_WRITE |-> !$past(registered_write_strobe_n))
        else $error("write cycle without write strobe");

    chk_select_decode: assert property (@(posedge clk) disable iff (reset)
        cycle_reg != SSR_CYC_IDLE |->
            $past(registered_chip_select) && !$past(registered_chip_select_n))
        else $error("cycle selected without both selects");

    chk_deselect_hiz: assert property (@(posedge clk) disable iff (reset)
        cycle_reg == SSR_CYC_IDLE |-> !data_lane_pins_oe && !low_lane_parity_oe)
        else $error("driving while deselected");

    chk_low_lane_we: assert property (@(posedge clk) disable iff (reset)
        mem_we[LANE_LO] == (cycle_reg == SSR_CYC_WRITE && !low_byte_write_strobe_n))
        else $error("low lane write enable wrong");

    chk_high_lane_we: assert property (@(posedge clk) disable iff (reset)
        mem_we[LANE_HI] == (cycle_reg == SSR_CYC_WRITE && !high_byte_write_strobe_n))
        else $error("high lane write enable wrong");

    chk_abort_quiet: assert property (@(posedge clk) disable iff (reset)
        (cycle_reg == SSR_CYC_WRITE && low_byte_write_strobe_n && high_byte_write_strobe_n)
            |-> mem_we == '0 && !data_lane_pins_oe)
        else $error("aborted write touched array or pins");

    chk_read_drive: assert property (@(posedge clk) disable iff (reset)
        cycle_reg == SSR_CYC_READ |-> data_lane_pins_oe == !output_enable_n)
        else $error("read drivers do not follow output enable");

    chk_write_no_drive: assert property (@(posedge clk) disable iff (reset)
        cycle_reg == SSR_CYC_WRITE |-> !data_lane_pins_oe && !high_lane_parity_oe)
        else $error("driving during write");

    chk_latch_hold: assert property (@(posedge clk) disable iff (reset)
        !input_latch_gate |=> held_reg == $past(held_reg))
        else $error("latched data changed with gate low");

    chk_latch_pass: assert property (@(posedge clk) disable iff (reset)
        input_latch_gate |-> wr_word == pin_word)
        else $error("latch not transparent");

    chk_write_readback: assert property (@(posedge clk) disable iff (reset)
        (cycle_reg == SSR_CYC_WRITE && mem_we == 2'b11) ##1
        (cycle_reg == SSR_CYC_READ && addr_reg == $past(addr_reg) && !output_enable_n)
            |-> {high_lane_parity_out, data_lane_pins_out[PINS_W-1:PIN_HI_LSB],
                 low_lane_parity_out, data_lane_pins_out[PIN_HI_LSB-1:0]} == $past(wr_word))
        else $error("read back differs from written word");

    cov_read: cover property (@(posedge clk) disable iff (reset)
        cycle_reg == SSR_CYC_READ && data_lane_pins_oe);
    cov_latched_write: cover property (@(posedge clk) disable iff (reset)
        cycle_reg == SSR_CYC_WRITE && !input_latch_gate && mem_we == 2'b11);
    cov_abort: cover property (@(posedge clk) disable iff (reset)
        cycle_reg == SSR_CYC_WRITE && mem_we == 2'b00);
    cov_byte_write: cover property (@(posedge clk) disable iff (reset)
        cycle_reg == SSR_CYC_WRITE && mem_we == 2'b10);
endmodule : ssr_core

// >>> verilog/ssr_mem_array.sv
`timescale 1ns/10ps
// Word array with per-lane write enables and a registered read port.
// A write and a read of the same word on one edge return the new lanes.
module ssr_mem_array
    import ssr_pkg::*;
#(
    parameter int AW    = ADDR_W,
    parameter int LW    = LANE_W,
    parameter int NL    = LANES,
    parameter int DEPTH = 16384
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [NL-1:0]    wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [NL*LW-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [NL*LW-1:0] rd_data
);
    logic [NL*LW-1:0] mem [DEPTH];
    logic [NL*LW-1:0] rd_next;

    always_comb begin
        rd_next = mem[rd_addr];
        for (int i = 0; i < NL; i++) begin
            if (wr_en[i] && (wr_addr == rd_addr)) begin
                rd_next[i*LW +: LW] = wr_data[i*LW +: LW];
            end
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < NL; i++) begin
            if (wr_en[i]) begin
                mem[wr_addr][i*LW +: LW] <= wr_data[i*LW +: LW];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rd_data <= WORD_RST;
        end else begin
            rd_data <= rd_next;
        end
    end
endmodule : ssr_mem_array

// >>> verilog/ssr_pkg.sv
package ssr_pkg;
    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W  = 14;
    localparam int BYTE_W  = 8;
    localparam int LANE_W  = 9;
    localparam int LANES   = 2;
    localparam int WORD_W  = 18;
    localparam int PINS_W  = 16;

    // Lane field positions inside a stored word: {hi_par, hi_byte, lo_par, lo_byte}
    localparam int LO_BYTE_LSB = 0;
    localparam int LO_PAR_BIT  = 8;
    localparam int HI_BYTE_LSB = 9;
    localparam int HI_PAR_BIT  = 17;
    localparam int PIN_HI_LSB  = 8;

    localparam int LANE_LO = 0;
    localparam int LANE_HI = 1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
    localparam logic [WORD_W-1:0] WORD_RST = 18'h00000;

    typedef enum logic [1:0] {
        SSR_CYC_IDLE  = 2'b00,
        SSR_CYC_READ  = 2'b01,
        SSR_CYC_WRITE = 2'b10
    } ssr_cycle_t;
endpackage : ssr_pkg
